//--- rtl/ohs_pkg.sv
// Shared constants and types for the origin homing sequencer.
// Assumes one 100 MHz clock and a synchronous active-high reset.
package ohs_pkg;
  // ==========================================================
  // Register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_FAST_SPEED = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_SLOW_SPEED = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_OFS_REV = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_OFS_PULSE = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_ORIGIN_POS = 8'h18;

  // ==========================================================
  // Control register fields
  localparam int DET_LSB = 0;
  localparam int DET_W = 3;
  localparam int SHORT_LSB = 3;
  localparam int SHORT_W = 2;
  localparam int START_LSB = 5;
  localparam int START_W = 2;
  localparam int STOP_BIT = 7;
  localparam int CMODE_LSB = 8;
  localparam int CMODE_W = 2;
  localparam int TRIG_SEL_LSB = 10;
  localparam int TRIG_SEL_W = 3;
  localparam int TRIG_EN_BIT = 13;

  // ==========================================================
  // Setting codes and limits
  localparam logic [DET_W-1:0] DET_CCW_LIMIT = 3'h0;
  localparam logic [DET_W-1:0] DET_CW_LIMIT = 3'h1;
  localparam logic [DET_W-1:0] DET_SENSOR_CW = 3'h2;
  localparam logic [DET_W-1:0] DET_SENSOR_CCW = 3'h3;
  localparam logic [DET_W-1:0] DET_INDEX_CW = 3'h4;
  localparam logic [DET_W-1:0] DET_MAX = 3'h5;
  localparam logic [SHORT_W-1:0] SHORT_REVERSE = 2'h0;
  localparam logic [SHORT_W-1:0] SHORT_FORWARD = 2'h1;
  localparam logic [SHORT_W-1:0] SHORT_EDGE = 2'h2;
  localparam logic [START_W-1:0] START_OFF = 2'h0;
  localparam logic [START_W-1:0] START_AUTO = 2'h1;
  localparam logic [START_W-1:0] START_TRIG = 2'h2;
  localparam logic STOP_PULLBACK = 1'b0;
  localparam logic [CMODE_W-1:0] CMODE_INT_POS = 2'h0;
  localparam int SPEED_W = 11;
  localparam logic [SPEED_W-1:0] SPEED_MIN = 11'h001;
  localparam logic [SPEED_W-1:0] FAST_MAX = 11'h7d0;
  localparam logic [SPEED_W-1:0] FAST_DEF = 11'h3e8;
  localparam logic [SPEED_W-1:0] SLOW_MAX = 11'h1f4;
  localparam logic [SPEED_W-1:0] SLOW_DEF = 11'h032;
  localparam logic signed [15:0] OFS_REV_MAX = 16'sh7530;
  localparam int DI_N = 8;

  // ==========================================================
  // Types
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_FAST = 6'h02,
    ST_SLOW = 6'h04,
    ST_DECEL = 6'h08,
    ST_RETURN = 6'h10,
    ST_DONE = 6'h20
  } ohs_state_type;

  typedef struct packed {
    logic run;
    logic dir_cw;
    logic [SPEED_W-1:0] speed;
    logic decel;
    logic go_target;
    logic [DATA_W-1:0] target;
  } ohs_motion_type;

  typedef struct packed {
    logic cw_limit;
    logic ccw_limit;
    logic origin;
    logic index;
    logic [DI_N-1:0] di;
  } ohs_pins_type;
endpackage

//--- rtl/ohs_pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes pins are asynchronous to ref_clk_i and held for several cycles.
`timescale 1ns/1ps
module ohs_pin_sync import ohs_pkg::*; #(
  parameter int WIDTH = 12
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Pins and filtered levels
  input wire logic [WIDTH-1:0] pins_i,
  output logic [WIDTH-1:0] levels_o
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // ==========================================================
  // Stages
  // The first stage feeds only the second, to keep metastability contained.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= pins_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // ==========================================================
  // Agreement filter
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      levels_o <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          levels_o[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule

//--- rtl/ohs_homing_sequencer.sv
// Homing sequencer: start policy, rough and precise origin search, stop.
// Assumes a motion loop that follows motion_o and reports stop and arrival.
//
// Function
// - Start mode 0 disables homing entirely.
// - Start mode 1 homes once automatically after power-up with servo on.
// - Start mode 2 homes on every trigger edge while the servo works.
// - Trigger needs a digital input pin mapped to the home trigger.
// - Detector 0 searches clockwise on the counter-clockwise limit; later hits warn.
// - Detector 1 searches counter-clockwise on the clockwise limit; later hits warn.
// - Limit references preferably refine on the index pulse.
// - Detectors 2 and 3 search cw or ccw on the origin sensor.
// - Detectors 4 and 5 search cw or ccw directly for the index pulse.
// - Short mode 0 reverses at slow speed to the nearest index.
// - Short mode 1 continues at slow speed to the nearest index.
// - Short mode 2 takes sensor edge or found index, then decelerates.
// - Stop mode 0 decelerates then drives back onto the origin.
// - Stop mode 1 stops forward, overrun uncorrected, origin unchanged.
// - Fast speed 1 to 2000 r/min, default 1000.
// - Slow speed 1 to 500 r/min, default 50.
// - Offset is signed revolutions within 30000 plus signed pulses.
// - Homing only runs in internal position control mode.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
module ohs_homing_sequencer import ohs_pkg::*; #(
  parameter int PULSES_PER_REV = 10000
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  // Drive status
  input wire logic servo_on_i,
  input wire logic motor_stopped_i,
  input wire logic at_target_i,
  input wire logic [DATA_W-1:0] position_i,
  // Pins
  input wire logic clockwise_limit_input_i,
  input wire logic counter_clockwise_limit_input_i,
  input wire logic external_origin_sensor_i,
  input wire logic index_pulse_i,
  input wire logic [DI_N-1:0] di_pins_i,
  // Motion and results
  output ohs_motion_type motion_o,
  output logic zero_set_o,
  output logic [DATA_W-1:0] zero_value_o,
  output logic homing_busy_o,
  output logic homing_done_o,
  output logic limit_warn_o
);
  localparam int PIN_W = $bits(ohs_pins_type);

  // ==========================================================
  // Functions
  function automatic logic [SPEED_W-1:0] clamp_speed(input logic [DATA_W-1:0] v,
                                                     input logic [SPEED_W-1:0] hi);
    if (v < DATA_W'(SPEED_MIN)) begin
      clamp_speed = SPEED_MIN;
    end else if (v > DATA_W'(hi)) begin
      clamp_speed = hi;
    end else begin
      clamp_speed = v[SPEED_W-1:0];
    end
  endfunction

  function automatic logic signed [DATA_W-1:0] clamp_signed(input logic signed [DATA_W-1:0] v,
                                                           input logic signed [DATA_W-1:0] hi);
    if (v > hi) begin
      clamp_signed = hi;
    end else if (v < -hi) begin
      clamp_signed = -hi;
    end else begin
      clamp_signed = v;
    end
  endfunction

  function automatic logic [DATA_W-1:0] clamp_code(input logic [DATA_W-1:0] v,
                                                   input logic [DATA_W-1:0] hi);
    clamp_code = (v > hi) ? hi : v;
  endfunction

  // ==========================================================
  // Settings
  logic [DET_W-1:0] det_reg;
  logic [SHORT_W-1:0] short_reg;
  logic [START_W-1:0] start_reg;
  logic stop_reg;
  logic [CMODE_W-1:0] cmode_reg;
  logic [TRIG_SEL_W-1:0] trig_sel_reg;
  logic trig_en_reg;
  logic [SPEED_W-1:0] fast_reg;
  logic [SPEED_W-1:0] slow_reg;
  logic signed [15:0] ofs_rev_reg;
  logic signed [DATA_W-1:0] ofs_pulse_reg;
  logic signed [DATA_W-1:0] ofs_pulse_max;

  assign ofs_pulse_max = DATA_W'(PULSES_PER_REV - 1);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      det_reg <= DET_CCW_LIMIT;
      short_reg <= SHORT_REVERSE;
      start_reg <= START_OFF;
      stop_reg <= STOP_PULLBACK;
      cmode_reg <= CMODE_INT_POS;
      trig_sel_reg <= '0;
      trig_en_reg <= 1'b0;
      fast_reg <= FAST_DEF;
      slow_reg <= SLOW_DEF;
      ofs_rev_reg <= '0;
      ofs_pulse_reg <= '0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == ADDR_CTRL) begin
        // Out-of-range codes saturate to the highest legal code.
        det_reg <= DET_W'(clamp_code(DATA_W'(reg_wdata_i[DET_LSB +: DET_W]),
                                     DATA_W'(DET_MAX)));
        short_reg <= SHORT_W'(clamp_code(DATA_W'(reg_wdata_i[SHORT_LSB +: SHORT_W]),
                                         DATA_W'(SHORT_EDGE)));
        start_reg <= START_W'(clamp_code(DATA_W'(reg_wdata_i[START_LSB +: START_W]),
                                         DATA_W'(START_TRIG)));
        stop_reg <= reg_wdata_i[STOP_BIT];
        cmode_reg <= reg_wdata_i[CMODE_LSB +: CMODE_W];
        trig_sel_reg <= reg_wdata_i[TRIG_SEL_LSB +: TRIG_SEL_W];
        trig_en_reg <= reg_wdata_i[TRIG_EN_BIT];
      end else if (reg_addr_i == ADDR_FAST_SPEED) begin
        fast_reg <= clamp_speed(reg_wdata_i, FAST_MAX);
      end else if (reg_addr_i == ADDR_SLOW_SPEED) begin
        slow_reg <= clamp_speed(reg_wdata_i, SLOW_MAX);
      end else if (reg_addr_i == ADDR_OFS_REV) begin
        ofs_rev_reg <= 16'(clamp_signed(reg_wdata_i, DATA_W'(OFS_REV_MAX)));
      end else if (reg_addr_i == ADDR_OFS_PULSE) begin
        ofs_pulse_reg <= clamp_signed(reg_wdata_i, ofs_pulse_max);
      end
    end
  end

  // ==========================================================
  // Pin synchronisation and edges
  ohs_pins_type pins_raw;
  ohs_pins_type pins_lvl;
  ohs_pins_type pins_prev_reg;

  assign pins_raw = '{cw_limit: clockwise_limit_input_i,
                      ccw_limit: counter_clockwise_limit_input_i,
                      origin: external_origin_sensor_i,
                      index: index_pulse_i,
                      di: di_pins_i};

  ohs_pin_sync #(
    .WIDTH(PIN_W)
  ) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pins_i(pins_raw),
    .levels_o(pins_lvl)
  );

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pins_prev_reg <= '0;
    end else begin
      pins_prev_reg <= pins_lvl;
    end
  end

  logic origin_rise;
  logic index_rise;
  logic trig_rise;

  assign origin_rise = pins_lvl.origin & ~pins_prev_reg.origin;
  assign index_rise = pins_lvl.index & ~pins_prev_reg.index;
  // Without a mapped pin no trigger request can reach the sequencer.
  assign trig_rise = trig_en_reg & pins_lvl.di[trig_sel_reg]
                     & ~pins_prev_reg.di[trig_sel_reg];

  // ==========================================================
  // Start policy
  logic mode_ok;
  logic auto_used_reg;
  logic start_req;
  logic abort;

  assign mode_ok = (cmode_reg == CMODE_INT_POS);
  assign start_req = servo_on_i & mode_ok
                     & (((start_reg == START_AUTO) & ~auto_used_reg)
                        | ((start_reg == START_TRIG) & trig_rise));
  assign abort = ~servo_on_i | ~mode_ok | (start_reg == START_OFF);

  // Automatic homing is spent once per power-up, not per servo enable.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      auto_used_reg <= 1'b0;
    end else if (start_req & (start_reg == START_AUTO)) begin
      auto_used_reg <= 1'b1;
    end
  end

  // ==========================================================
  // Search decode
  logic rough_hit;
  logic sensor_det;
  logic index_det;
  logic start_dir_cw;

  assign sensor_det = (det_reg == DET_SENSOR_CW) | (det_reg == DET_SENSOR_CCW);
  assign index_det = (det_reg >= DET_INDEX_CW);
  // Even codes search clockwise, odd codes counter-clockwise.
  assign start_dir_cw = ~det_reg[0];

  always_comb begin
    if (det_reg == DET_CCW_LIMIT) begin
      rough_hit = pins_lvl.ccw_limit;
    end else if (det_reg == DET_CW_LIMIT) begin
      rough_hit = pins_lvl.cw_limit;
    end else if (sensor_det) begin
      rough_hit = origin_rise;
    end else begin
      rough_hit = 1'b0;
    end
  end

  // ==========================================================
  // Sequencer
  ohs_state_type state_reg;
  logic dir_cw_reg;
  logic [DATA_W-1:0] origin_pos_reg;
  logic done_reg;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      dir_cw_reg <= 1'b0;
    end else if (abort) begin
      state_reg <= ST_IDLE;
    end else if (start_req) begin
      dir_cw_reg <= start_dir_cw;
      // Index detectors have no rough stage, so they go straight to slow search.
      state_reg <= index_det ? ST_SLOW : ST_FAST;
    end else begin
      case (state_reg)
        ST_FAST: begin
          if (rough_hit) begin
            if ((short_reg == SHORT_EDGE) & sensor_det) begin
              state_reg <= ST_DECEL;
            end else begin
              // Limit references refine on the index; edge mode falls back to it.
              if (short_reg == SHORT_REVERSE) begin
                dir_cw_reg <= ~dir_cw_reg;
              end
              state_reg <= ST_SLOW;
            end
          end
        end
        ST_SLOW: begin
          if (index_rise) begin
            state_reg <= ST_DECEL;
          end
        end
        ST_DECEL: begin
          if (motor_stopped_i) begin
            state_reg <= (stop_reg == STOP_PULLBACK) ? ST_RETURN : ST_DONE;
          end
        end
        ST_RETURN: begin
          if (at_target_i) begin
            state_reg <= ST_DONE;
          end
        end
        ST_DONE: begin
          state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Origin capture
  // The origin is the position at the detecting edge, so overrun never moves it.
  logic capture;

  assign capture = ~abort & ~start_req
                   & (((state_reg == ST_FAST) & rough_hit & (short_reg == SHORT_EDGE)
                       & sensor_det)
                      | ((state_reg == ST_SLOW) & index_rise));

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      origin_pos_reg <= '0;
    end else if (capture) begin
      origin_pos_reg <= position_i;
    end
  end

  // ==========================================================
  // Completion and zero setting
  logic signed [DATA_W-1:0] ofs_total;

  assign ofs_total = DATA_W'(ofs_rev_reg * PULSES_PER_REV) + ofs_pulse_reg;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      done_reg <= 1'b0;
      zero_set_o <= 1'b0;
      zero_value_o <= '0;
    end else begin
      zero_set_o <= ~abort & (state_reg == ST_DONE);
      if (~abort & (state_reg == ST_DONE)) begin
        done_reg <= 1'b1;
        zero_value_o <= ofs_total;
      end else if (start_req) begin
        done_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Motion command
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      motion_o <= '0;
    end else begin
      motion_o.run <= (state_reg == ST_FAST) | (state_reg == ST_SLOW);
      motion_o.dir_cw <= dir_cw_reg;
      motion_o.speed <= (state_reg == ST_FAST) ? fast_reg : slow_reg;
      motion_o.decel <= (state_reg == ST_DECEL);
      motion_o.go_target <= (state_reg == ST_RETURN);
      motion_o.target <= origin_pos_reg;
    end
  end

  // ==========================================================
  // Limit warning
  // A limit in use as the rough reference is silent only while homing runs.
  logic homing_active;

  assign homing_active = (state_reg != ST_IDLE);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      limit_warn_o <= 1'b0;
    end else begin
      limit_warn_o <= (pins_lvl.ccw_limit & ~(homing_active & (det_reg == DET_CCW_LIMIT)))
                      | (pins_lvl.cw_limit & ~(homing_active & (det_reg == DET_CW_LIMIT)));
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      homing_busy_o <= 1'b0;
      homing_done_o <= 1'b0;
    end else begin
      homing_busy_o <= homing_active & ~abort;
      homing_done_o <= done_reg;
    end
  end

  // ==========================================================
  // Register read port
  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    if (reg_addr_i == ADDR_CTRL) begin
      rd_mux[DET_LSB +: DET_W] = det_reg;
      rd_mux[SHORT_LSB +: SHORT_W] = short_reg;
      rd_mux[START_LSB +: START_W] = start_reg;
      rd_mux[STOP_BIT] = stop_reg;
      rd_mux[CMODE_LSB +: CMODE_W] = cmode_reg;
      rd_mux[TRIG_SEL_LSB +: TRIG_SEL_W] = trig_sel_reg;
      rd_mux[TRIG_EN_BIT] = trig_en_reg;
    end else if (reg_addr_i == ADDR_FAST_SPEED) begin
      rd_mux = DATA_W'(fast_reg);
    end else if (reg_addr_i == ADDR_SLOW_SPEED) begin
      rd_mux = DATA_W'(slow_reg);
    end else if (reg_addr_i == ADDR_OFS_REV) begin
      rd_mux = DATA_W'(signed'(ofs_rev_reg));
    end else if (reg_addr_i == ADDR_OFS_PULSE) begin
      rd_mux = ofs_pulse_reg;
    end else if (reg_addr_i == ADDR_STATUS) begin
      rd_mux = {20'h00000, limit_warn_o, done_reg, homing_active, auto_used_reg,
                pins_lvl.index, pins_lvl.origin, state_reg};
    end else if (reg_addr_i == ADDR_ORIGIN_POS) begin
      rd_mux = origin_pos_reg;
    end
  end

  // Read data stand only in the cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : '0;
    end
  end
endmodule

//--- bench/ohs_homing_sequencer_sva.sv
// Port checks for the homing sequencer, bound into every instance.
// Assumes the single ref_clk_i domain with synchronous active-high rst_i.
`timescale 1ns/1ps
module ohs_port_checker import ohs_pkg::*; (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Observed ports
  input wire logic servo_on_i,
  input wire logic motor_stopped_i,
  input wire logic at_target_i,
  input wire ohs_motion_type motion_o,
  input wire logic zero_set_o,
  input wire logic [DATA_W-1:0] zero_value_o,
  input wire logic homing_busy_o,
  input wire logic homing_done_o
);
  // ==========================================================
  // Properties
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  zero_pulse_a: assert property (
    zero_set_o |=> !zero_set_o) else $error("zero pulse longer than one cycle");
  done_marks_zero_a: assert property (
    $rose(homing_done_o) |-> $past(zero_set_o)) else $error("done without zero pulse");
  zero_value_held_a: assert property (
    !zero_set_o |-> $stable(zero_value_o)) else $error("zero value moved without pulse");
  speed_range_a: assert property (
    motion_o.run |-> motion_o.speed inside {[SPEED_MIN:FAST_MAX]})
    else $error("search speed out of range");
  servo_abort_a: assert property (
    !servo_on_i [*4] |-> !homing_busy_o && !motion_o.run) else $error("homing without servo");
  decel_hold_a: assert property (
    motion_o.decel && !motor_stopped_i && servo_on_i |=> motion_o.decel)
    else $error("decel dropped before stop");
  return_hold_a: assert property (
    motion_o.go_target && !at_target_i && servo_on_i |=> motion_o.go_target)
    else $error("return dropped before arrival");
  one_command_a: assert property (
    motion_o.run |-> !motion_o.decel && !motion_o.go_target) else $error("mixed motion command");
  fast_then_slow_a: assert property (
    $past(motion_o.run) && motion_o.run && motion_o.speed != $past(motion_o.speed)
    |-> motion_o.speed <= SLOW_MAX) else $error("speed change not to slow stage");
endmodule

bind ohs_homing_sequencer ohs_port_checker port_chk (
  .ref_clk_i,
  .rst_i,
  .servo_on_i,
  .motor_stopped_i,
  .at_target_i,
  .motion_o,
  .zero_set_o,
  .zero_value_o,
  .homing_busy_o,
  .homing_done_o
);

//--- bench/ohs_motor_model.sv
// Motor, encoder index, origin sensor and limit switches behind the drive.
// Assumes one position step per cycle; pin windows repeat along the travel.
`timescale 1ns/1ps
module ohs_motor_model import ohs_pkg::*; (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Drive side
  input wire ohs_motion_type motion_i,
  input wire logic [3:0] stop_lat_i,
  output logic motor_stopped_o,
  output logic at_target_o,
  output logic [DATA_W-1:0] position_o,
  // Pins
  output logic cw_limit_o,
  output logic ccw_limit_o,
  output logic origin_o,
  output logic index_o
);
  // ==========================================================
  // Motion
  logic [3:0] idle_reg;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      position_o <= '0;
    end else if (motion_i.run) begin
      position_o <= motion_i.dir_cw ? position_o + 1 : position_o - 1;
    end else if (motion_i.go_target && position_o != motion_i.target) begin
      position_o <= ($signed(position_o) < $signed(motion_i.target)) ? position_o + 1
        : position_o - 1;
    end
  end
  // A slow latency stretches deceleration so the drive must wait for it.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || motion_i.run) begin
      idle_reg <= '0;
    end else if (idle_reg != 4'hf) begin
      idle_reg <= idle_reg + 4'h1;
    end
  end
  assign motor_stopped_o = idle_reg > stop_lat_i;
  assign at_target_o = motion_i.go_target && position_o == motion_i.target;
  // Windows repeat so a search finds them from either side.
  assign index_o = position_o[5:0] < 6'h08;
  assign origin_o = position_o[7:0] >= 8'h3c && position_o[7:0] <= 8'h5a;
  assign ccw_limit_o = position_o[8:0] >= 9'h190 && position_o[8:0] <= 9'h1ae;
  assign cw_limit_o = position_o[8:0] >= 9'h0c8 && position_o[8:0] <= 9'h0e6;
endmodule

//--- bench/test_origin_homing_sequencer.sv
// Self-checking bench: register access, start policy and homing sequences.
// Assumes the port checker is bound from its own file.
`timescale 1ns/1ps
module test_origin_homing_sequencer import ohs_pkg::*; ;
  localparam int PPR = 10000;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i = '0;
  logic [DATA_W-1:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic servo_on_i = 1'b0;
  logic [DI_N-1:0] di_pins_i = '0;
  logic [3:0] stop_lat = 4'h1;
  logic [DATA_W-1:0] reg_rdata_o;
  logic [DATA_W-1:0] zero_value_o;
  logic [DATA_W-1:0] position;
  ohs_motion_type motion_o;
  logic zero_set_o, homing_busy_o, homing_done_o, stopped, arrived;
  logic cw_lim, ccw_lim, origin, index, warn;
  int fail_count = 0;
  int tests_run = 0;
  logic [ADDR_W-1:0] ra[6] = '{ADDR_CTRL, ADDR_FAST_SPEED, ADDR_SLOW_SPEED, ADDR_OFS_REV,
    ADDR_OFS_PULSE, 8'h1c};
  int re[6] = '{0, 1000, 50, 0, 0, 0};
  logic [ADDR_W-1:0] wa[5] = '{ADDR_FAST_SPEED, ADDR_FAST_SPEED, ADDR_SLOW_SPEED,
    ADDR_OFS_REV, 8'h1c};
  int wd[5] = '{0, 3000, 600, 40000, 5};
  int we[5] = '{1, 2000, 500, 30000, 0};
  int cd[8] = '{0, 1, 2, 3, 4, 5, 2, 0};
  int cs[8] = '{0, 1, 0, 1, 0, 2, 2, 2};
  int cp[8] = '{0, 1, 0, 1, 1, 0, 1, 0};

  ohs_homing_sequencer #(.PULSES_PER_REV(PPR)) DUT (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .servo_on_i(servo_on_i),
    .motor_stopped_i(stopped),
    .at_target_i(arrived),
    .position_i(position),
    .clockwise_limit_input_i(cw_lim),
    .counter_clockwise_limit_input_i(ccw_lim),
    .external_origin_sensor_i(origin),
    .index_pulse_i(index),
    .di_pins_i(di_pins_i),
    .motion_o(motion_o),
    .zero_set_o(zero_set_o),
    .zero_value_o(zero_value_o),
    .homing_busy_o(homing_busy_o),
    .homing_done_o(homing_done_o),
    .limit_warn_o(warn)
  );

  ohs_motor_model motor (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .motion_i(motion_o),
    .stop_lat_i(stop_lat),
    .motor_stopped_o(stopped),
    .at_target_o(arrived),
    .position_o(position),
    .cw_limit_o(cw_lim),
    .ccw_limit_o(ccw_lim),
    .origin_o(origin),
    .index_o(index)
  );

  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // ==========================================================
  // Tasks
  task automatic end_sim();
    if (fail_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
    input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Each access leaves one idle edge, so strobes never toggle twice in a step.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge ref_clk_i);
    cmp(reg_rdata_o, exp, "register read");
    @(posedge ref_clk_i);
  endtask

  function automatic logic [DATA_W-1:0] ctrl(input int det, sh, st, stp, cm, en);
    return DATA_W'(det | sh << SHORT_LSB | st << START_LSB | stp << STOP_BIT
      | cm << CMODE_LSB | 3 << TRIG_SEL_LSB | en << TRIG_EN_BIT);
  endfunction

  task automatic home(input int det, input int sh, input int stp, input int st);
    logic fdir, sdir, back, cw, esd;
    int n;
    fdir = 1'bx;
    sdir = 1'bx;
    back = 1'b0;
    cw = (det % 2 == 0);
    esd = det >= 4 ? cw : (sh == 2 && det >= 2) ? 1'bx : (sh == 0) ? !cw : cw;
    n = 0;
    wr(ADDR_CTRL, ctrl(det, sh, st, stp, 0, 1));
    di_pins_i[3] <= 1'b1;
    while (zero_set_o !== 1'b1 && n < 3000) begin
      @(posedge ref_clk_i);
      if (n == 8) di_pins_i[3] <= 1'b0;
      @(negedge ref_clk_i);
      n++;
      if (motion_o.run === 1'b1 && motion_o.speed === FAST_MAX) fdir = motion_o.dir_cw;
      if (motion_o.run === 1'b1 && motion_o.speed === SLOW_MAX) sdir = motion_o.dir_cw;
      if (motion_o.go_target === 1'b1) back = 1'b1;
    end
    if (n >= 3000) begin
      cmp(1'b0, 1'b1, "homing hang");
      end_sim();
    end
    cmp(fdir, det < 4 ? cw : 1'bx, "fast dir");
    cmp(sdir, esd, "slow dir");
    cmp(back, stp == 0, "pull back");
    cmp(zero_value_o, DATA_W'(PPR + 5), "offset");
    @(posedge ref_clk_i);
    if (stp == 0) chk_rd(ADDR_ORIGIN_POS, position);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    servo_on_i <= 1'b1;
    @(posedge ref_clk_i);
    for (int i = 0; i < 6; i++) chk_rd(ra[i], re[i]);
    for (int i = 0; i < 5; i++) begin
      wr(wa[i], wd[i]);
      chk_rd(wa[i], we[i]);
    end
    wr(ADDR_OFS_REV, 1);
    wr(ADDR_OFS_PULSE, 5);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, ctrl(2, 0, i == 0 ? 0 : 2, 0, i == 2, i != 1));
      di_pins_i[3] <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      di_pins_i[3] <= 1'b0;
      repeat (12) @(negedge ref_clk_i);
      cmp(homing_busy_o, 1'b0, "no start");
      @(posedge ref_clk_i);
    end
    home(2, 0, 0, 1);
    servo_on_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    servo_on_i <= 1'b1;
    repeat (40) @(negedge ref_clk_i);
    cmp(homing_busy_o, 1'b0, "auto repeat");
    cmp(warn, cw_lim | ccw_lim, "limit warn");
    @(posedge ref_clk_i);
    for (int i = 0; i < 8; i++) begin
      stop_lat <= i[0] ? 4'h9 : 4'h1;
      home(cd[i], cs[i], cp[i], 2);
    end
    wr(ADDR_CTRL, ctrl(4, 0, 2, 0, 0, 1));
    di_pins_i[3] <= 1'b1;
    repeat (12) @(posedge ref_clk_i);
    servo_on_i <= 1'b0;
    repeat (6) @(negedge ref_clk_i);
    cmp({homing_busy_o, homing_done_o, zero_set_o}, 3'b000, "abort");
    end_sim();
  end
endmodule
